// ===== oam_pkg.sv
// Purpose: shared types and constants for the link management sublayer
// Assumes: 25 MHz core clock, byte-wide frame streams
// Notes: frame beats carry a last marker and a management-frame mark
package oam_pkg;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] data;
		logic last;
		logic mgmt;
	} beat_t;

	typedef struct packed {
		logic [15:0] flags;
		logic [7:0] code;
	} mgmt_hdr_t;

	typedef struct packed {
		logic crit_event;
		logic dying_gasp;
		logic link_fault;
	} crit_t;

	typedef enum logic [1:0] {fault_only_perm, silent_perm, only_perm_a, any_perm} perm_t;
	typedef enum logic [1:0] {pass_through, echo_back, discard_act} act_t;

	// ----------------------------------------
	// flags field layout and codes
	// ----------------------------------------
	localparam int FLG_REM_STABLE = 6;
	localparam int FLG_REM_EVAL = 5;
	localparam int FLG_LOC_STABLE = 4;
	localparam int FLG_LOC_EVAL = 3;
	localparam int FLG_LINK_FAULT = 0;
	localparam logic [1:0] STAB_EVAL_BAD = 2'h3;
	localparam logic [7:0] CODE_ONLY_PERM_A = 8'h00;
	localparam logic [1:0] IDX_FLAGS_HI = 2'h0;
	localparam logic [1:0] IDX_FLAGS_LO = 2'h1;
	localparam logic [1:0] IDX_CODE = 2'h2;

	// ----------------------------------------
	// budget and timing
	// ----------------------------------------
	localparam logic [3:0] PDU_BUDGET = 4'ha;
	localparam int CLK_KHZ = 25000;
	localparam int PDU_TIME_MS = 1000;
	localparam int LOST_LINK_TIME_MS = 5000;
	localparam int PDU_TIMER_CYC = PDU_TIME_MS * CLK_KHZ;
	localparam int LOST_LINK_CYC = LOST_LINK_TIME_MS * CLK_KHZ;

endpackage

// ===== two_entry_buf.sv
// Purpose: two-entry buffer with valid/ready on both sides
// Assumes: single clock, asynchronous active-high reset
// Notes: full when two words held; in_ready_o drops then
`timescale 1ns/10ps
`default_nettype none
module two_entry_buf #(
	parameter int W = 10,
	parameter int DEPTH = 2
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	input wire logic [W-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [W-1:0] out_data_o,
	input wire logic out_ready_i
);
	logic [W-1:0] mem_reg [DEPTH];
	logic wr_ptr_reg;
	logic rd_ptr_reg;
	logic [1:0] count_reg;
	logic push;
	logic pop;

	assign in_ready_o = (count_reg != 2'(DEPTH));
	assign out_valid_o = (count_reg != 2'h0);
	assign out_data_o = mem_reg[rd_ptr_reg];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_ff @(posedge core_clk_i) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data_i;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr_reg <= 1'b0;
			rd_ptr_reg <= 1'b0;
			count_reg <= 2'h0;
		end else begin
			if (push) begin
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop) begin
				rd_ptr_reg <= ~rd_ptr_reg;
			end
			count_reg <= count_reg + 2'(push) - 2'(pop);
		end
	end
endmodule
`default_nettype wire

// ===== link_oam_ctrl.sv
// Purpose: link management sublayer: discovery flags, transmit, mux, parser
// Assumes: byte streams with last marker; inputs synchronous to core_clk_i
// Notes: management frames carry flags (2 bytes) then code (1 byte)
`timescale 1ns/10ps
`default_nettype none
module link_oam_ctrl
	import oam_pkg::*;
#(
	parameter int PDU_TIMER_CYCLES = oam_pkg::PDU_TIMER_CYC,
	parameter int LOST_LINK_CYCLES = oam_pkg::LOST_LINK_CYC
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic discovery_start_i,
	input wire logic client_sat_i,
	input wire logic client_unsat_i,
	input wire logic perm_load_i,
	input wire oam_pkg::perm_t perm_cfg_i,
	input wire logic unidir_i,
	input wire logic link_ok_i,
	input wire oam_pkg::act_t mux_act_i,
	input wire oam_pkg::act_t par_act_i,
	input wire logic oam_req_valid_i,
	input wire oam_pkg::mgmt_hdr_t oam_req_i,
	output logic oam_req_ready_o,
	input wire oam_pkg::crit_t crit_req_i,
	output logic crit_taken_o,
	input wire logic client_tx_valid_i,
	input wire oam_pkg::beat_t client_tx_i,
	output logic client_tx_ready_o,
	output logic mac_tx_valid_o,
	output oam_pkg::beat_t mac_tx_o,
	input wire logic mac_tx_ready_i,
	input wire logic mac_rx_valid_i,
	input wire oam_pkg::beat_t mac_rx_i,
	output logic mac_rx_ready_o,
	output logic client_rx_valid_o,
	output oam_pkg::beat_t client_rx_o,
	input wire logic client_rx_ready_i,
	output logic oam_ind_o,
	output oam_pkg::mgmt_hdr_t oam_ind_hdr_o,
	output logic lost_link_o,
	output logic local_stable_o,
	output logic local_eval_o,
	output oam_pkg::perm_t perm_o,
	output logic [3:0] budget_o
);
	import oam_pkg::*;

	typedef enum {TX_RESET, TX_WAIT, TX_SEND, TX_DEC} tx_state_t;
	typedef enum {MX_WAIT, MX_CHECK, MX_OAM, MX_FRAME, MX_DROP} mx_state_t;
	typedef enum {PS_WAIT, PS_CLASSIFY, PS_MGMT, PS_FWD, PS_ECHO, PS_DROP} ps_state_t;

	// ----------------------------------------
	// discovery status flags
	// ----------------------------------------
	logic loc_stable_reg;
	logic loc_eval_reg;
	logic rem_stable_reg;
	logic rem_eval_reg;
	logic rem_valid_reg;
	perm_t perm_reg;
	logic [15:0] base_flags;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			loc_stable_reg <= 1'b0;
			loc_eval_reg <= 1'b1;
		end else if (discovery_start_i) begin
			loc_stable_reg <= 1'b0;
			loc_eval_reg <= 1'b1;
		end else if (client_unsat_i) begin
			loc_stable_reg <= 1'b0;
			loc_eval_reg <= 1'b0;
		end else if (client_sat_i) begin
			loc_stable_reg <= 1'b1;
			loc_eval_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			perm_reg <= silent_perm;
		end else if (perm_load_i) begin
			perm_reg <= perm_cfg_i;
		end else if ({loc_stable_reg, loc_eval_reg, rem_stable_reg, rem_eval_reg} == 4'ha) begin
			perm_reg <= any_perm;
		end
	end

	always_comb begin
		base_flags = '0;
		base_flags[FLG_LOC_STABLE] = loc_stable_reg;
		base_flags[FLG_LOC_EVAL] = loc_eval_reg;
		base_flags[FLG_REM_STABLE] = rem_valid_reg & rem_stable_reg;
		base_flags[FLG_REM_EVAL] = rem_valid_reg & rem_eval_reg;
		base_flags[FLG_LINK_FAULT] = (perm_reg == fault_only_perm);
	end

	// ----------------------------------------
	// transmit controller
	// ----------------------------------------
	tx_state_t tx_state_reg;
	logic [31:0] pdu_tmr_reg;
	logic pdu_exp_reg;
	logic sent_reg;
	logic [3:0] budget_reg;
	logic mgmt_pend_reg;
	logic mgmt_crit_reg;
	mgmt_hdr_t mgmt_hdr_reg;
	logic mgmt_take;
	logic crit_req;
	logic norm_valid;
	logic crit_valid;
	logic tx_idle_send;

	assign crit_req = |crit_req_i;
	assign norm_valid = oam_req_valid_i && !crit_req && budget_reg != 4'h0 &&
		(perm_reg == any_perm || (perm_reg == only_perm_a && oam_req_i.code == CODE_ONLY_PERM_A));
	assign crit_valid = crit_req && perm_reg == any_perm;
	assign tx_idle_send = pdu_exp_reg && !sent_reg && perm_reg != silent_perm;
	assign oam_req_ready_o = tx_state_reg == TX_WAIT && !crit_valid && norm_valid;
	assign crit_taken_o = tx_state_reg == TX_WAIT && crit_valid;
	assign budget_o = budget_reg;

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pdu_tmr_reg <= '0;
			pdu_exp_reg <= 1'b0;
		end else if (tx_state_reg == TX_RESET) begin
			pdu_tmr_reg <= '0;
			pdu_exp_reg <= 1'b0;
		end else if (pdu_tmr_reg == 32'(PDU_TIMER_CYCLES - 1)) begin
			pdu_exp_reg <= 1'b1;
		end else begin
			pdu_tmr_reg <= pdu_tmr_reg + 32'h1;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_state_reg <= TX_RESET;
			budget_reg <= PDU_BUDGET;
			sent_reg <= 1'b0;
			mgmt_pend_reg <= 1'b0;
			mgmt_crit_reg <= 1'b0;
			mgmt_hdr_reg <= '0;
		end else begin
			unique case (tx_state_reg)
				TX_RESET: begin
					budget_reg <= PDU_BUDGET;
					sent_reg <= 1'b0;
					tx_state_reg <= TX_WAIT;
				end
				TX_WAIT: begin
					if (crit_valid) begin
						mgmt_hdr_reg <= '{flags: base_flags | 16'(crit_req_i), code: CODE_ONLY_PERM_A};
						mgmt_crit_reg <= 1'b1;
						mgmt_pend_reg <= 1'b1;
						tx_state_reg <= TX_SEND;
					end else if (norm_valid) begin
						mgmt_hdr_reg <= '{flags: base_flags, code: oam_req_i.code};
						mgmt_crit_reg <= 1'b0;
						mgmt_pend_reg <= 1'b1;
						tx_state_reg <= TX_SEND;
					end else if (tx_idle_send) begin
						mgmt_hdr_reg <= '{flags: base_flags, code: CODE_ONLY_PERM_A};
						mgmt_crit_reg <= 1'b1;
						mgmt_pend_reg <= 1'b1;
						tx_state_reg <= TX_SEND;
					end else if (pdu_exp_reg) begin
						tx_state_reg <= TX_RESET;
					end
				end
				TX_SEND: begin
					if (mgmt_take) begin
						mgmt_pend_reg <= 1'b0;
						sent_reg <= 1'b1;
						if (!mgmt_crit_reg) begin
							tx_state_reg <= TX_DEC;
						end else if (pdu_exp_reg) begin
							tx_state_reg <= TX_RESET;
						end else begin
							tx_state_reg <= TX_WAIT;
						end
					end
				end
				TX_DEC: begin
					budget_reg <= budget_reg - 4'h1;
					tx_state_reg <= pdu_exp_reg ? TX_RESET : TX_WAIT;
				end
			endcase
		end
	end

	// ----------------------------------------
	// multiplexer
	// ----------------------------------------
	mx_state_t mx_state_reg;
	logic src_echo_reg;
	logic [1:0] oam_idx_reg;
	beat_t tx_out_reg;
	logic tx_out_valid_reg;
	logic can_load;
	logic echo_valid;
	beat_t echo_beat;
	logic echo_ready;
	logic src_valid;
	beat_t src_beat;
	logic src_take;
	beat_t oam_beat;

	assign can_load = !tx_out_valid_reg || mac_tx_ready_i;
	assign mac_tx_valid_o = tx_out_valid_reg;
	assign mac_tx_o = tx_out_reg;
	assign src_valid = src_echo_reg ? echo_valid : client_tx_valid_i;
	assign src_beat = src_echo_reg ? echo_beat : client_tx_i;
	assign src_take = src_valid && ((mx_state_reg == MX_FRAME && can_load) ||
		mx_state_reg == MX_DROP);
	assign client_tx_ready_o = src_take && !src_echo_reg;
	assign echo_ready = src_take && src_echo_reg;
	assign mgmt_take = mx_state_reg == MX_OAM && can_load && oam_idx_reg == IDX_CODE;

	always_comb begin
		oam_beat = '{data: mgmt_hdr_reg.code, last: 1'b1, mgmt: 1'b1};
		if (oam_idx_reg == IDX_FLAGS_HI) begin
			oam_beat = '{data: mgmt_hdr_reg.flags[15:8], last: 1'b0, mgmt: 1'b1};
		end else if (oam_idx_reg == IDX_FLAGS_LO) begin
			oam_beat = '{data: mgmt_hdr_reg.flags[7:0], last: 1'b0, mgmt: 1'b1};
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tx_out_reg <= '0;
			tx_out_valid_reg <= 1'b0;
		end else if (can_load) begin
			tx_out_valid_reg <= 1'b0;
			if (mx_state_reg == MX_OAM) begin
				tx_out_reg <= oam_beat;
				tx_out_valid_reg <= 1'b1;
			end else if (mx_state_reg == MX_FRAME && src_valid) begin
				tx_out_reg <= src_beat;
				tx_out_valid_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mx_state_reg <= MX_WAIT;
			src_echo_reg <= 1'b0;
			oam_idx_reg <= IDX_FLAGS_HI;
		end else begin
			unique case (mx_state_reg)
				MX_WAIT: begin
					oam_idx_reg <= IDX_FLAGS_HI;
					if (mgmt_pend_reg) begin
						mx_state_reg <= MX_OAM;
					end else if (client_tx_valid_i && mux_act_i == pass_through) begin
						src_echo_reg <= 1'b0;
						mx_state_reg <= MX_CHECK;
					end else if (echo_valid) begin
						src_echo_reg <= 1'b1;
						mx_state_reg <= MX_CHECK;
					end
				end
				MX_CHECK: begin
					mx_state_reg <= (!unidir_i || link_ok_i) ? MX_FRAME : MX_DROP;
				end
				MX_OAM: begin
					if (can_load) begin
						oam_idx_reg <= oam_idx_reg + 2'h1;
						if (oam_idx_reg == IDX_CODE) begin
							mx_state_reg <= MX_WAIT;
						end
					end
				end
				MX_FRAME, MX_DROP: begin
					// the frame runs to its last beat before anything else goes
					if (src_take && src_beat.last) begin
						mx_state_reg <= MX_WAIT;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// parser
	// ----------------------------------------
	ps_state_t ps_state_reg;
	logic [1:0] rx_idx_reg;
	mgmt_hdr_t rx_hdr_reg;
	logic rx_take;
	logic rx_rdy;
	logic echo_in_ready;
	beat_t rx_out_reg;
	logic rx_out_valid_reg;
	logic rx_can_load;
	logic ind_reg;
	mgmt_hdr_t ind_hdr_reg;
	logic [31:0] lost_tmr_reg;
	logic lost_reg;
	logic restart_lost;
	mgmt_hdr_t rx_hdr_next;

	assign rx_can_load = !rx_out_valid_reg || client_rx_ready_i;
	always_comb begin
		unique case (ps_state_reg)
			PS_MGMT, PS_DROP: rx_rdy = 1'b1;
			PS_FWD: rx_rdy = rx_can_load;
			PS_ECHO: rx_rdy = echo_in_ready;
			default: rx_rdy = 1'b0;
		endcase
	end
	assign mac_rx_ready_o = rx_rdy;
	assign rx_take = mac_rx_valid_i && rx_rdy;
	assign client_rx_valid_o = rx_out_valid_reg;
	assign client_rx_o = rx_out_reg;
	assign oam_ind_o = ind_reg;
	assign oam_ind_hdr_o = ind_hdr_reg;
	assign lost_link_o = lost_reg;
	assign local_stable_o = loc_stable_reg;
	assign local_eval_o = loc_eval_reg;
	assign perm_o = perm_reg;
	assign restart_lost = rx_take && ps_state_reg == PS_MGMT && mac_rx_i.last;

	always_comb begin
		rx_hdr_next = rx_hdr_reg;
		if (rx_idx_reg == IDX_FLAGS_HI) begin
			rx_hdr_next.flags[15:8] = mac_rx_i.data;
		end else if (rx_idx_reg == IDX_FLAGS_LO) begin
			rx_hdr_next.flags[7:0] = mac_rx_i.data;
		end else if (rx_idx_reg == IDX_CODE) begin
			rx_hdr_next.code = mac_rx_i.data;
		end
	end

	two_entry_buf #(.W($bits(beat_t)), .DEPTH(2)) u_echo_buf (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.in_valid_i(mac_rx_valid_i && ps_state_reg == PS_ECHO),
		.in_data_i(mac_rx_i & ~beat_t'(1)),
		.in_ready_o(echo_in_ready),
		.out_valid_o(echo_valid),
		.out_data_o(echo_beat),
		.out_ready_i(echo_ready)
	);

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rx_out_reg <= '0;
			rx_out_valid_reg <= 1'b0;
		end else if (rx_can_load) begin
			rx_out_valid_reg <= rx_take && ps_state_reg == PS_FWD;
			if (rx_take && ps_state_reg == PS_FWD) begin
				rx_out_reg <= mac_rx_i;
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ps_state_reg <= PS_WAIT;
			rx_idx_reg <= IDX_FLAGS_HI;
			rx_hdr_reg <= '0;
			ind_reg <= 1'b0;
			ind_hdr_reg <= '0;
		end else begin
			ind_reg <= 1'b0;
			unique case (ps_state_reg)
				PS_WAIT: begin
					rx_idx_reg <= IDX_FLAGS_HI;
					rx_hdr_reg <= '0;
					if (mac_rx_valid_i) begin
						ps_state_reg <= PS_CLASSIFY;
					end
				end
				PS_CLASSIFY: begin
					if (mac_rx_i.mgmt) begin
						ps_state_reg <= PS_MGMT;
					end else if (par_act_i == pass_through) begin
						ps_state_reg <= PS_FWD;
					end else if (par_act_i == echo_back) begin
						ps_state_reg <= PS_ECHO;
					end else begin
						ps_state_reg <= PS_DROP;
					end
				end
				PS_MGMT: begin
					if (rx_take) begin
						rx_hdr_reg <= rx_hdr_next;
						if (rx_idx_reg != IDX_CODE + 2'h1) begin
							rx_idx_reg <= rx_idx_reg + 2'h1;
						end
						if (mac_rx_i.last) begin
							ind_reg <= perm_reg == any_perm || rx_hdr_next.code == CODE_ONLY_PERM_A;
							ind_hdr_reg <= rx_hdr_next;
							ps_state_reg <= PS_WAIT;
						end
					end
				end
				PS_FWD, PS_ECHO, PS_DROP: begin
					if (rx_take && mac_rx_i.last) begin
						ps_state_reg <= PS_WAIT;
					end
				end
			endcase
		end
	end

	// remote discovery status kept from received information frames
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rem_stable_reg <= 1'b0;
			rem_eval_reg <= 1'b0;
			rem_valid_reg <= 1'b0;
		end else if (restart_lost && rx_hdr_next.code == CODE_ONLY_PERM_A &&
			rx_hdr_next.flags[FLG_LOC_STABLE:FLG_LOC_EVAL] != STAB_EVAL_BAD) begin
			rem_stable_reg <= rx_hdr_next.flags[FLG_LOC_STABLE];
			rem_eval_reg <= rx_hdr_next.flags[FLG_LOC_EVAL];
			rem_valid_reg <= 1'b1;
		end else if (discovery_start_i || lost_reg) begin
			rem_valid_reg <= 1'b0;
			rem_stable_reg <= 1'b0;
			rem_eval_reg <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			lost_tmr_reg <= '0;
			lost_reg <= 1'b0;
		end else if (restart_lost) begin
			lost_tmr_reg <= '0;
			lost_reg <= 1'b0;
		end else if (lost_tmr_reg == 32'(LOST_LINK_CYCLES - 1)) begin
			lost_tmr_reg <= '0;
			lost_reg <= 1'b1;
		end else begin
			lost_tmr_reg <= lost_tmr_reg + 32'h1;
			lost_reg <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ===== link_oam_monitor.sv
// Purpose: port checker for link_oam_ctrl
// Assumes: one clock, async high reset
// Notes: attached by bind below
`timescale 1ns/10ps
`default_nettype none
module link_oam_monitor
	import oam_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic discovery_start_i,
	input wire logic client_sat_i,
	input wire logic client_unsat_i,
	input wire oam_pkg::mgmt_hdr_t oam_req_i,
	input wire logic oam_req_ready_o,
	input wire logic crit_taken_o,
	input wire logic mac_tx_valid_o,
	input wire oam_pkg::beat_t mac_tx_o,
	input wire logic mac_tx_ready_i,
	input wire logic client_rx_valid_o,
	input wire oam_pkg::beat_t client_rx_o,
	input wire logic client_rx_ready_i,
	input wire logic local_stable_o,
	input wire logic local_eval_o,
	input wire oam_pkg::perm_t perm_o,
	input wire logic [3:0] budget_o
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	AST_DISC_START: assert property (discovery_start_i |=> !local_stable_o && local_eval_o)
		else $error("start pulse gave wrong flags");
	AST_UNSAT: assert property (client_unsat_i && !discovery_start_i |=> !local_stable_o && !local_eval_o)
		else $error("unsatisfied pulse gave wrong flags");
	AST_SAT: assert property (client_sat_i && !client_unsat_i && !discovery_start_i
		|=> local_stable_o && !local_eval_o)
		else $error("satisfied pulse gave wrong flags");
	AST_NO_BAD: assert property (!(local_stable_o && local_eval_o))
		else $error("reserved flag pair driven");
	AST_SILENT: assert property (perm_o == silent_perm |-> !oam_req_ready_o && !crit_taken_o)
		else $error("request taken while silent");
	AST_CRIT_ANY: assert property (crit_taken_o |-> perm_o == any_perm)
		else $error("critical taken without any permission");
	AST_REQ_OK: assert property (oam_req_ready_o
		|-> budget_o != 4'h0 && (perm_o == any_perm
		|| perm_o == only_perm_a && oam_req_i.code == CODE_ONLY_PERM_A))
		else $error("request taken when not valid");
	AST_BUDGET_STEP: assert property (budget_o != $past(budget_o)
		|-> budget_o == $past(budget_o) - 4'h1 || budget_o == PDU_BUDGET)
		else $error("budget moved by a wrong step");
	AST_TX_HOLD: assert property (mac_tx_valid_o && !mac_tx_ready_i
		|=> mac_tx_valid_o && $stable(mac_tx_o))
		else $error("mac beat changed while stalled");
	AST_RX_HOLD: assert property (client_rx_valid_o && !client_rx_ready_i
		|=> client_rx_valid_o && $stable(client_rx_o))
		else $error("client beat changed while stalled");
endmodule
bind link_oam_ctrl link_oam_monitor mon_inst (.core_clk_i, .rst_i, .discovery_start_i,
	.client_sat_i, .client_unsat_i, .oam_req_i, .oam_req_ready_o, .crit_taken_o,
	.mac_tx_valid_o, .mac_tx_o, .mac_tx_ready_i, .client_rx_valid_o, .client_rx_o,
	.client_rx_ready_i, .local_stable_o, .local_eval_o, .perm_o, .budget_o);
`default_nettype wire

// ===== mac_model.sv
// Purpose: far-side mac model
// Assumes: beats move on valid and ready at the edge
// Notes: stall_i holds tx ready low; one stall cycle in four otherwise
`timescale 1ns/10ps
`default_nettype none
module mac_model
	import oam_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic stall_i,
	input wire logic mac_tx_valid_i,
	input wire oam_pkg::beat_t mac_tx_i,
	output logic mac_tx_ready_o,
	output logic mac_rx_valid_o,
	output oam_pkg::beat_t mac_rx_o,
	input wire logic mac_rx_ready_i
);
	beat_t tx_q[$];
	logic [1:0] ph = 2'h0;
	initial begin
		mac_tx_ready_o = 1'b0;
		mac_rx_valid_o = 1'b0;
		mac_rx_o = '0;
	end
	always @(posedge core_clk_i) begin
		ph <= ph + 2'h1;
		mac_tx_ready_o <= !stall_i && ph != 2'h0;
		if (mac_tx_valid_i && mac_tx_ready_o)
			tx_q.push_back(mac_tx_i);
	end
	// first byte from the top of b; released line shows the inverse
	task automatic send_frame(input logic m, input int n, input logic [63:0] b);
		for (int i = 0; i < n; i++) begin
			mac_rx_valid_o <= 1'b1;
			mac_rx_o <= '{b[8*(n-1-i) +: 8], i == n - 1, m};
			do @(posedge core_clk_i); while (mac_rx_ready_i !== 1'b1);
		end
		mac_rx_valid_o <= 1'b0;
		mac_rx_o <= ~mac_rx_o;
	endtask
endmodule
`default_nettype wire

// ===== link_oam_ctrl_tb.sv
// Purpose: self-checking bench for link_oam_ctrl
// Assumes: shortened timers, mac_model as far side
// Notes: discovery pulses from a table, then hand cases
`timescale 1ns/10ps
`default_nettype none
module link_oam_ctrl_tb;
	import oam_pkg::*;
	logic core_clk_i, rst_i, unidir_i, link_ok_i, oam_req_valid_i, client_tx_valid_i, stall;
	logic client_rx_ready_i, mac_tx_ready_i, mac_rx_valid_i, mac_rx_ready_o, oam_req_ready_o;
	logic crit_taken_o, client_tx_ready_o, mac_tx_valid_o, client_rx_valid_o, oam_ind_o;
	logic lost_link_o, local_stable_o, local_eval_o;
	logic [3:0] pls, budget_o;
	perm_t perm_cfg_i, perm_o;
	act_t mux_act_i, par_act_i;
	mgmt_hdr_t oam_req_i, oam_ind_hdr_o;
	crit_t crit_req_i;
	beat_t client_tx_i, mac_tx_o, mac_rx_i, client_rx_o;
	beat_t rx_q[$];
	int errors = 0, cmp_count = 0, ticks = 0, ind_cnt = 0, lost_cnt = 0, k;
	logic [5:0] rows [6] = '{6'h21, 6'h10, 6'h0a, 6'h31, 6'h18, 6'h0a};
	link_oam_ctrl #(.PDU_TIMER_CYCLES(200), .LOST_LINK_CYCLES(1000)) link_oam_ctrl_inst (
		.core_clk_i, .rst_i, .discovery_start_i(pls[3]), .client_unsat_i(pls[2]),
		.client_sat_i(pls[1]), .perm_load_i(pls[0]), .perm_cfg_i, .unidir_i, .link_ok_i,
		.mux_act_i, .par_act_i, .oam_req_valid_i, .oam_req_i, .oam_req_ready_o, .crit_req_i,
		.crit_taken_o, .client_tx_valid_i, .client_tx_i, .client_tx_ready_o, .mac_tx_valid_o,
		.mac_tx_o, .mac_tx_ready_i, .mac_rx_valid_i, .mac_rx_i, .mac_rx_ready_o,
		.client_rx_valid_o, .client_rx_o, .client_rx_ready_i, .oam_ind_o, .oam_ind_hdr_o,
		.lost_link_o, .local_stable_o, .local_eval_o, .perm_o, .budget_o);
	mac_model mac (.core_clk_i, .stall_i(stall), .mac_tx_valid_i(mac_tx_valid_o),
		.mac_tx_i(mac_tx_o), .mac_tx_ready_o(mac_tx_ready_i), .mac_rx_valid_o(mac_rx_valid_i),
		.mac_rx_o(mac_rx_i), .mac_rx_ready_i(mac_rx_ready_o));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	initial begin
		core_clk_i = 1'b0;
		forever #20 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		ticks <= ticks + 1;
		client_rx_ready_i <= ticks[0];
		if (oam_ind_o === 1'b1) ind_cnt <= ind_cnt + 1;
		if (lost_link_o === 1'b1) lost_cnt <= lost_cnt + 1;
		if (client_rx_valid_o && client_rx_ready_i) rx_q.push_back(client_rx_o);
		if (ticks == 8000) begin
			errors++;
			print_verdict();
		end
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask
	task automatic go(input logic [3:0] p, input perm_t c);
		perm_cfg_i <= c;
		pls <= p;
		cyc(1);
		pls <= 4'h0;
		cyc(1);
	endtask
	// frame is flags high, flags low, code
	task automatic chk_frame(input logic [23:0] exp);
		for (k = 0; k < 600 && mac.tx_q.size() < 3; k++) cyc(1);
		for (int i = 0; i < 3; i++)
			chk({mac.tx_q[i].data, mac.tx_q[i].last}, {exp[8*(2-i) +: 8], i == 2});
	endtask
	task automatic req(input logic [7:0] code, input crit_t c);
		oam_req_i <= {16'h0000, code};
		oam_req_valid_i <= (c == 3'h0);
		crit_req_i <= c;
		k = 0;
		do begin
			cyc(1);
			k++;
		end while (oam_req_ready_o !== 1'b1 && crit_taken_o !== 1'b1 && k < 300);
		oam_req_valid_i <= 1'b0;
		crit_req_i <= 3'h0;
	endtask
	task automatic client_send(input logic [23:0] b);
		for (int i = 0; i < 3; i++) begin
			client_tx_valid_i <= 1'b1;
			client_tx_i <= '{b[8*(2-i) +: 8], i == 2, 1'b0};
			k = 0;
			do begin
				cyc(1);
				k++;
			end while (client_tx_ready_o !== 1'b1 && k < 50);
		end
		client_tx_valid_i <= 1'b0;
		client_tx_i <= ~client_tx_i;
	endtask
	task automatic print_verdict();
		$display("errors=%0d compares=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		rst_i = 1'b1;
		pls = 4'h0;
		perm_cfg_i = silent_perm;
		unidir_i = 1'b0;
		link_ok_i = 1'b1;
		mux_act_i = pass_through;
		par_act_i = pass_through;
		oam_req_valid_i = 1'b0;
		oam_req_i = '0;
		crit_req_i = 3'h0;
		client_tx_valid_i = 1'b0;
		client_tx_i = '0;
		stall = 1'b0;
		cyc(6);
		rst_i <= 1'b0;
		cyc(2);
		chk({local_stable_o, local_eval_o, perm_o, budget_o}, 8'h5a);
		foreach (rows[i]) begin
			go(rows[i][5:2], silent_perm);
			chk({local_stable_o, local_eval_o}, rows[i][1:0]);
		end
		go(4'h1, fault_only_perm);
		mac.tx_q.delete();
		chk_frame(24'h001100);
		chk(budget_o, 4'ha);
		go(4'h1, only_perm_a);
		req(8'h01, 3'h0);
		chk(k, 300);
		cyc(2);
		req(8'h00, 3'h0);
		chk(k < 300, 1'b1);
		go(4'h1, silent_perm);
		cyc(30);
		mac.tx_q.delete();
		cyc(450);
		chk(mac.tx_q.size(), 0);
		mac.send_frame(1'b1, 3, 24'h001800);
		cyc(6);
		chk({perm_o, ind_cnt[3:0]}, {silent_perm, 4'h1});
		mac.send_frame(1'b1, 3, 24'h000001);
		cyc(6);
		chk(ind_cnt, 1);
		mac.send_frame(1'b1, 3, 24'h001000);
		cyc(6);
		chk({perm_o, ind_cnt[3:0]}, {any_perm, 4'h2});
		// reserved pair must not overwrite the remote pair now held
		mac.send_frame(1'b1, 3, 24'h001800);
		cyc(6);
		mac.send_frame(1'b1, 3, 24'h000007);
		cyc(6);
		chk({oam_ind_hdr_o, ind_cnt[3:0]}, {24'h000007, 4'h4});
		mac.tx_q.delete();
		chk_frame(24'h005000);
		mac.tx_q.delete();
		req(8'h01, 3'h0);
		chk_frame(24'h005001);
		cyc(3);
		chk(budget_o, 4'h9);
		mac.tx_q.delete();
		req(8'h00, 3'h4);
		chk_frame(24'h005400);
		cyc(3);
		chk(budget_o, 4'h9);
		for (k = 0; k < 300 && budget_o !== 4'ha; k++) cyc(1);
		chk(budget_o, 4'ha);
		go(4'h5, silent_perm);
		chk(perm_o, silent_perm);
		mac.send_frame(1'b0, 3, 24'ha1b2c3);
		cyc(10);
		chk({rx_q.size(), rx_q[0].data, rx_q[1].data, rx_q[2].data, rx_q[2].last},
			{32'h3, 24'ha1b2c3, 1'b1});
		par_act_i <= discard_act;
		mac.tx_q.delete();
		cyc(2);
		mac.send_frame(1'b0, 3, 24'h010203);
		cyc(10);
		chk(rx_q.size() + mac.tx_q.size(), 3);
		par_act_i <= echo_back;
		stall <= 1'b1;
		cyc(2);
		fork
			mac.send_frame(1'b0, 8, 64'h1122334455667788);
			begin
				cyc(30);
				chk(mac_rx_valid_i, 1'b1);
				stall <= 1'b0;
			end
		join
		cyc(20);
		for (int i = 0; i < 8; i++)
			chk({mac.tx_q[i].data, mac.tx_q[i].mgmt}, {8'(8'h11 * (i + 1)), 1'b0});
		mac.tx_q.delete();
		client_send(24'hc0ffee);
		cyc(10);
		chk_frame(24'hc0ffee);
		unidir_i <= 1'b1;
		link_ok_i <= 1'b0;
		mac.tx_q.delete();
		client_send(24'h0badad);
		cyc(10);
		chk(mac.tx_q.size(), 0);
		mux_act_i <= echo_back;
		link_ok_i <= 1'b1;
		client_send(24'h123456);
		cyc(10);
		chk(mac.tx_q.size(), 0);
		// any management frame restarts the lost-link count
		mac.send_frame(1'b1, 3, 24'h000001);
		cyc(2);
		k = lost_cnt;
		cyc(990);
		chk(lost_cnt, k);
		cyc(20);
		chk(lost_cnt, k + 1);
		print_verdict();
	end
endmodule
`default_nettype wire
